// ---- verilog/pue_unpack_engine.sv ----
// pixel rectangle unpack engine with AXI4-Lite registers
// assumes memory answers each one-cycle read request once, later,
// with the addressed element right-justified in memRdData
// ------------------------------------------------------------------
// Overview of operation
// - groups hold one to four elements in format order; i-formats integer
// - stencil, depth, both or color target chosen by format
// - byte reversal: 8-bit kept, 16-bit swapped, 32-bit fully reversed
// - reversal defined only for 8, 16 and 32-bit elements
// - row N starts at base plus N times pitch, padded to alignment
// - odd element widths ignore alignment for pitch
// - skip pixels times n plus skip rows times pitch before first group
// - width contiguous groups per row, next row from row start
// - packed types other than the float depth stencil pair take all components from one word
// - float depth stencil pair: depth word then stencil in low byte
// - packed types carry fixed component counts of three, four or two
// - packed type and format mismatch raises error, transfer rejected
// - field widths follow the packed type digits
// - normal types pack first component high, reversed types low
// - field top bit is the component top bit, no bit reversal
// - packed components right-justified in the pixel word
// - byte reversal happens before field extraction
// - row length zero means width groups per row
// ------------------------------------------------------------------
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
module pue_unpack_engine import pue_pkg::*; (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output pue_mem_req_type memReq,
	input wire logic [31:0] memRdData,
	input wire logic memRdValid,
	output pue_group_type grpOut,
	output logic irq
);

	// ------------------------------------------------------------------
	// decode functions
	// ------------------------------------------------------------------
	function automatic logic isPacked(input logic [4:0] t);
		return t >= T_332;
	endfunction

	function automatic logic [3:0] elemBytes(input logic [4:0] t);
		case (t)
			T_UBYTE, T_BYTE, T_332, T_233R: return 4'h1;
			T_USHORT, T_SHORT, T_HALF: return 4'h2;
			T_565, T_565R, T_4444, T_4444R, T_5551, T_1555R: return 4'h2;
			default: return 4'h4;
		endcase
	endfunction

	// element width in bits, kept at six bits so 32 fits
	function automatic logic [5:0] elemBits(input logic [3:0] s);
		case (s)
			4'h1: return 6'd8;
			4'h2: return 6'd16;
			default: return 6'd32;
		endcase
	endfunction

	// elements per group and format meaning
	function automatic logic [2:0] fmtCount(input logic [4:0] f);
		case (f)
			F_DEPTH_STENCIL, F_RG, F_RG_I: return 3'h2;
			F_RGB, F_BGR, F_RGB_I, F_BGR_I: return 3'h3;
			F_RGBA, F_REV_FOUR, F_RGBA_I, F_REV_FOUR_I: return 3'h4;
			default: return 3'h1;
		endcase
	endfunction

	// fixed component counts of packed types
	function automatic logic [2:0] packedCount(input logic [4:0] t);
		case (t)
			T_332, T_233R, T_565, T_565R, T_F111110R: return 3'h3;
			T_24_8, T_FDS_PAIR: return 3'h2;
			default: return 3'h4;
		endcase
	endfunction

	function automatic logic cfgMismatch(input logic [4:0] t,
			input logic [4:0] f);
		logic match;
		match = 1'b0;
		if (!isPacked(t)) begin
			match = 1'b1;
		end else if (packedCount(t) == fmtCount(f)) begin
			case (t)
				T_24_8, T_FDS_PAIR: match = (f == F_DEPTH_STENCIL);
				T_332, T_233R, T_565, T_565R, T_F111110R, T_5999R:
					match = (f == F_RGB);
				default: match = (f == F_RGBA) || (f == F_REV_FOUR);
			endcase
		end
		return !match;
	endfunction

	// field widths, listed last to first component
	function automatic logic [3:0][5:0] fieldWidths(input logic [4:0] t);
		case (t)
			T_332: return {6'd0, 6'd2, 6'd3, 6'd3};
			T_233R: return {6'd0, 6'd2, 6'd3, 6'd3};
			T_565, T_565R: return {6'd0, 6'd5, 6'd6, 6'd5};
			T_4444, T_4444R: return {6'd4, 6'd4, 6'd4, 6'd4};
			T_5551, T_1555R: return {6'd1, 6'd5, 6'd5, 6'd5};
			T_8888, T_8888R: return {6'd8, 6'd8, 6'd8, 6'd8};
			T_1010102, T_2101010R: return {6'd2, 6'd10, 6'd10, 6'd10};
			T_24_8: return {6'd0, 6'd0, 6'd8, 6'd24};
			T_F111110R: return {6'd0, 6'd10, 6'd11, 6'd11};
			T_5999R: return {6'd5, 6'd9, 6'd9, 6'd9};
			default: return '0;
		endcase
	endfunction

	function automatic logic isRev(input logic [4:0] t);
		case (t)
			T_233R, T_565R, T_4444R, T_1555R, T_8888R: return 1'b1;
			T_2101010R, T_F111110R, T_5999R: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	function automatic logic [3:0][31:0] unpackFields(input logic [31:0] w,
			input logic [4:0] t);
		logic [3:0][31:0] c;
		logic [3:0][5:0] wd;
		logic [5:0] pos;
		c = '0;
		wd = fieldWidths(t);
		// container is exactly the element size
		pos = isRev(t) ? 6'd0 : elemBits(elemBytes(t));
		for (int i = 0; i < 4; i++) begin
			// normal from the top, reversed from bit 0
			if (!isRev(t)) begin
				pos = pos - wd[i];
			end
			// plain shift keeps field bit order
			c[i] = (w >> pos) & ((32'h1 << wd[i]) - 32'h1);
			if (isRev(t)) begin
				pos = pos + wd[i];
			end
		end
		return c;
	endfunction

	function automatic logic [31:0] byteSwap(input logic [31:0] w,
			input logic [3:0] s);
		case (s)
			4'h1: return {24'h0, w[7:0]};
			4'h2: return {16'h0, w[7:0], w[15:8]};
			default: return {w[7:0], w[15:8], w[23:16], w[31:24]};
		endcase
	endfunction

	// row pitch in bytes, padded to alignment
	function automatic logic [31:0] pitchBytes(input logic [31:0] nl,
			input logic [3:0] s, input logic [3:0] a);
		logic [31:0] raw;
		raw = 32'(nl * {28'h0, s});
		// alignment ignored for odd element widths
		if (s >= a || !(s == 4'h1 || s == 4'h2 || s == 4'h4 || s == 4'h8)) begin
			return raw;
		end
		return (raw + {28'h0, a} - 32'h1) & ~({28'h0, a} - 32'h1);
	endfunction

	function automatic logic [31:0] applyStrb(input logic [31:0] old,
			input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return r;
	endfunction

	// ------------------------------------------------------------------
	// registers and state
	// ------------------------------------------------------------------
	logic swapEn, startReq, evtDone, evtErr, busy, lastErr;
	logic [4:0] fmtSel, typeSel;
	logic [3:0] align;
	logic [15:0] rowLen, skipRows, skipPix, width, height;
	logic [31:0] base, groupCnt, pitch, elemPtr, rowStart;
	logic [1:0] intStatus, intMask;
	logic [7:0] awaddrQ;
	logic [31:0] wdataQ;
	logic [3:0] wstrbQ, elemSize;
	logic [2:0] nElem, idx;
	logic [15:0] grpIdx, rowIdx;
	logic [3:0][31:0] elem;
	logic [31:0] next_rdata;
	logic rdHit, wrHit, wrDo, rdDo, cfgBad;
	pue_state_type state;

	assign wrDo = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	assign rdDo = s_axi_arvalid && s_axi_arready;
	assign wrHit = awaddrQ[1:0] == 2'h0 && awaddrQ <= REG_INT_MASK;
	assign rdHit = s_axi_araddr[1:0] == 2'h0 && s_axi_araddr <= REG_GROUP_CNT;
	assign cfgBad = cfgMismatch(typeSel, fmtSel);
	assign busy = state != S_IDLE;

	// ------------------------------------------------------------------
	// write channel
	// ------------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			awaddrQ <= 8'h00;
			wdataQ <= 32'h0;
			wstrbQ <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awaddrQ <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wdataQ <= s_axi_wdata;
				wstrbQ <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wrDo) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wrHit ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// config writes are not blocked while busy; host keeps them stable
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			swapEn <= 1'b0;
			startReq <= 1'b0;
			fmtSel <= 5'h00;
			typeSel <= 5'h00;
			align <= ALIGN_RESET;
			rowLen <= 16'h0;
			skipRows <= 16'h0;
			skipPix <= 16'h0;
			width <= 16'h0;
			height <= 16'h0;
			base <= 32'h0;
			intMask <= 2'h0;
		end else begin
			startReq <= 1'b0;
			if (wrDo) begin
				case (awaddrQ)
					REG_CTRL: begin
						if (wstrbQ[0]) begin
							swapEn <= wdataQ[CTRL_SWAP_BIT];
							startReq <= wdataQ[CTRL_START_BIT] && !busy;
						end
					end
					REG_FORMAT: fmtSel <= 5'(applyStrb({27'h0, fmtSel},
						wdataQ, wstrbQ));
					REG_TYPE: typeSel <= 5'(applyStrb({27'h0, typeSel},
						wdataQ, wstrbQ));
					REG_ALIGN: begin
						// only 1, 2, 4 or 8 is taken
						if (wstrbQ[0] && wdataQ[7:4] == 4'h0 && wdataQ[3:0] != 4'h0
								&& (wdataQ[3:0] & (wdataQ[3:0] - 4'h1)) == 4'h0) begin
							align <= wdataQ[3:0];
						end
					end
					REG_ROW_LEN: rowLen <= 16'(applyStrb({16'h0, rowLen},
						wdataQ, wstrbQ));
					REG_SKIP_ROWS: skipRows <= 16'(applyStrb({16'h0, skipRows},
						wdataQ, wstrbQ));
					REG_SKIP_PIX: skipPix <= 16'(applyStrb({16'h0, skipPix},
						wdataQ, wstrbQ));
					REG_WIDTH: width <= 16'(applyStrb({16'h0, width},
						wdataQ, wstrbQ));
					REG_HEIGHT: height <= 16'(applyStrb({16'h0, height},
						wdataQ, wstrbQ));
					REG_BASE: base <= applyStrb(base, wdataQ, wstrbQ);
					REG_INT_MASK: intMask <= 2'(applyStrb({30'h0, intMask},
						wdataQ, wstrbQ));
					default: ;
				endcase
			end
		end
	end

	// ------------------------------------------------------------------
	// read channel
	// ------------------------------------------------------------------
	always_comb begin
		case (s_axi_araddr)
			REG_CTRL: next_rdata = {30'h0, swapEn, 1'b0};
			REG_FORMAT: next_rdata = {27'h0, fmtSel};
			REG_TYPE: next_rdata = {27'h0, typeSel};
			REG_ALIGN: next_rdata = {28'h0, align};
			REG_ROW_LEN: next_rdata = {16'h0, rowLen};
			REG_SKIP_ROWS: next_rdata = {16'h0, skipRows};
			REG_SKIP_PIX: next_rdata = {16'h0, skipPix};
			REG_WIDTH: next_rdata = {16'h0, width};
			REG_HEIGHT: next_rdata = {16'h0, height};
			REG_BASE: next_rdata = base;
			REG_STATUS: next_rdata = {30'h0, lastErr, busy};
			REG_INT_STATUS: next_rdata = {30'h0, intStatus};
			REG_INT_MASK: next_rdata = {30'h0, intMask};
			REG_GROUP_CNT: next_rdata = groupCnt;
			default: next_rdata = 32'h0;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= RESP_OKAY;
		end else if (rdDo) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rdHit ? next_rdata : 32'h0;
			s_axi_rresp <= rdHit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// interrupt status, read-to-clear; a new event beats the clear
	// ------------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			intStatus <= 2'h0;
			irq <= 1'b0;
		end else begin
			intStatus <= ((rdDo && s_axi_araddr == REG_INT_STATUS) ? 2'h0 : intStatus)
				| {evtErr, evtDone};
			irq <= |(intStatus & intMask);
		end
	end

	// ------------------------------------------------------------------
	// transfer engine
	// ------------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state <= S_IDLE;
			evtDone <= 1'b0;
			evtErr <= 1'b0;
			lastErr <= 1'b0;
			memReq <= '0;
			elemSize <= 4'h1;
			nElem <= 3'h1;
			idx <= 3'h0;
			pitch <= 32'h0;
			elemPtr <= 32'h0;
			rowStart <= 32'h0;
			grpIdx <= 16'h0;
			rowIdx <= 16'h0;
			elem <= '0;
		end else begin
			evtDone <= 1'b0;
			evtErr <= 1'b0;
			memReq.valid <= 1'b0;
			case (state)
				S_IDLE: begin
					if (startReq) begin
						lastErr <= cfgBad;
						if (cfgBad) begin
							evtErr <= 1'b1;
						end else if (width == 16'h0 || height == 16'h0) begin
							evtDone <= 1'b1;
						end else begin
							state <= S_SETUP;
						end
					end
				end
				S_SETUP: begin
					elemSize <= elemBytes(typeSel);
					// the pair is two 32-bit words per group
					nElem <= typeSel == T_FDS_PAIR ? 3'h2
						: isPacked(typeSel) ? 3'h1 : fmtCount(fmtSel);
					state <= S_SKIP;
				end
				S_SKIP: begin
					// row length zero falls back to width
					pitch <= pitchBytes(32'({16'h0, rowLen == 16'h0 ? width : rowLen}
						* {29'h0, nElem}), elemSize, align);
					state <= S_FETCH;
				end
				S_FETCH: begin
					if (rowIdx == 16'h0 && grpIdx == 16'h0 && idx == 3'h0) begin
						// skip offsets before the first group
						elemPtr <= base + 32'({16'h0, skipPix} * {29'h0, nElem}
							* {28'h0, elemSize}) + 32'({16'h0, skipRows} * pitch);
						// row start keeps the skip-pixel offset for every row
						rowStart <= base + 32'({16'h0, skipPix} * {29'h0, nElem}
							* {28'h0, elemSize}) + 32'({16'h0, skipRows} * pitch);
						memReq.addr <= base + 32'({16'h0, skipPix} * {29'h0, nElem}
							* {28'h0, elemSize}) + 32'({16'h0, skipRows} * pitch);
					end else begin
						memReq.addr <= elemPtr;
					end
					memReq.valid <= 1'b1;
					state <= S_WAIT;
				end
				S_WAIT: begin
					if (memRdValid) begin
						// reversal before any field is taken
						elem[idx] <= swapEn ? byteSwap(memRdData, elemSize)
							: memRdData & (32'hffffffff >> (6'd32 - elemBits(elemSize)));
						elemPtr <= memReq.addr + {28'h0, elemSize};
						if (idx == nElem - 3'h1) begin
							state <= S_EMIT;
						end else begin
							idx <= idx + 3'h1;
							state <= S_FETCH;
						end
					end
				end
				S_EMIT: begin
					idx <= 3'h0;
					// next row from row start plus pitch
					if (grpIdx == width - 16'h1) begin
						grpIdx <= 16'h0;
						rowStart <= rowStart + pitch;
						elemPtr <= rowStart + pitch;
						if (rowIdx == height - 16'h1) begin
							rowIdx <= 16'h0;
							evtDone <= 1'b1;
							state <= S_IDLE;
						end else begin
							rowIdx <= rowIdx + 16'h1;
							state <= S_FETCH;
						end
					end else begin
						grpIdx <= grpIdx + 16'h1;
						state <= S_FETCH;
					end
				end
				default: state <= S_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// group output
	// ------------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			grpOut <= '0;
			groupCnt <= 32'h0;
		end else begin
			grpOut.valid <= state == S_EMIT;
			if (state == S_IDLE && startReq) begin
				groupCnt <= 32'h0;
			end
			if (state == S_EMIT) begin
				groupCnt <= groupCnt + 32'h1;
				grpOut.count <= isPacked(typeSel) ? packedCount(typeSel)
					: fmtCount(fmtSel);
				case (fmtSel)
					F_STENCIL: grpOut.target <= TGT_STENCIL;
					F_DEPTH: grpOut.target <= TGT_DEPTH;
					F_DEPTH_STENCIL: grpOut.target <= TGT_DEPTH_STENCIL;
					default: grpOut.target <= TGT_COLOR;
				endcase
				grpOut.stencilIndex <= fmtSel == F_STENCIL
					|| fmtSel == F_DEPTH_STENCIL;
				grpOut.integerComps <= fmtSel >= F_RED_I;
				if (typeSel == T_FDS_PAIR) begin
					// depth word, stencil in low byte of second
					grpOut.comp <= {64'h0, 24'h0, elem[1][7:0], elem[0]};
				end else if (isPacked(typeSel)) begin
					grpOut.comp <= unpackFields(elem[0], typeSel);
				end else begin
					grpOut.comp <= elem;
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	sequence seqReqThenWait;
		memReq.valid ##1 (state == S_WAIT);
	endsequence

	AST_REQ_ONE_CYCLE: assert property (@(posedge mclk) disable iff (sys_rst)
		(state == S_FETCH) |=> seqReqThenWait ##0 !memReq.valid)
		else $error("read request not a single pulse");
	AST_REJECT: assert property (@(posedge mclk) disable iff (sys_rst)
		(state == S_IDLE && startReq && cfgBad) |=> (state == S_IDLE && evtErr)
		##1 intStatus[INT_ERR_BIT])
		else $error("mismatched transfer not rejected");
	AST_NO_BAD_RUN: assert property (@(posedge mclk) disable iff (sys_rst)
		(state == S_SETUP) |-> !cfgBad)
		else $error("transfer started with mismatched type");
	AST_PITCH_ALIGN: assert property (@(posedge mclk) disable iff (sys_rst)
		(state == S_FETCH && elemSize < align) |-> (pitch % {28'h0, align}) == 32'h0)
		else $error("row pitch not aligned");
	AST_SWAP32: assert property (@(posedge mclk) disable iff (sys_rst)
		(state == S_WAIT && memRdValid && swapEn && elemSize == 4'h4)
		|=> elem[$past(idx)] == {$past(memRdData[7:0]), $past(memRdData[15:8]),
		$past(memRdData[23:16]), $past(memRdData[31:24])})
		else $error("32-bit byte reversal wrong");
	AST_565_FIELDS: assert property (@(posedge mclk) disable iff (sys_rst)
		(state == S_EMIT && typeSel == T_565) |=> grpOut.valid
		&& grpOut.comp[0] == {27'h0, elem[0][15:11]}
		&& grpOut.comp[2] == {27'h0, elem[0][4:0]})
		else $error("5-6-5 field placement wrong");
	AST_565R_FIELDS: assert property (@(posedge mclk) disable iff (sys_rst)
		(state == S_EMIT && typeSel == T_565R) |=> grpOut.comp[0]
		== {27'h0, elem[0][4:0]} && grpOut.comp[1] == {26'h0, elem[0][10:5]})
		else $error("reversed 5-6-5 field placement wrong");
	AST_ROUTE_DS: assert property (@(posedge mclk) disable iff (sys_rst)
		(state == S_EMIT && fmtSel == F_DEPTH_STENCIL)
		|=> grpOut.target == TGT_DEPTH_STENCIL && grpOut.stencilIndex)
		else $error("depth-stencil routed wrongly");
	AST_ROW_STEP: assert property (@(posedge mclk) disable iff (sys_rst)
		(state == S_EMIT && grpIdx == width - 16'h1 && rowIdx != height - 16'h1)
		|=> elemPtr == $past(rowStart) + pitch ##1 memReq.addr == $past(elemPtr))
		else $error("row advance not from row start");

endmodule // pue_unpack_engine

// ---- common/pue_pkg.sv ----
// pixel unpack engine: shared constants, codes, carriers
// assumes a single 25 MHz clock domain and AXI4-Lite register access
package pue_pkg;

	// ------------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_FORMAT = 8'h04;
	localparam logic [7:0] REG_TYPE = 8'h08;
	localparam logic [7:0] REG_ALIGN = 8'h0c;
	localparam logic [7:0] REG_ROW_LEN = 8'h10;
	localparam logic [7:0] REG_SKIP_ROWS = 8'h14;
	localparam logic [7:0] REG_SKIP_PIX = 8'h18;
	localparam logic [7:0] REG_WIDTH = 8'h1c;
	localparam logic [7:0] REG_HEIGHT = 8'h20;
	localparam logic [7:0] REG_BASE = 8'h24;
	localparam logic [7:0] REG_STATUS = 8'h28;
	localparam logic [7:0] REG_INT_STATUS = 8'h2c;
	localparam logic [7:0] REG_INT_MASK = 8'h30;
	localparam logic [7:0] REG_GROUP_CNT = 8'h34;

	// ------------------------------------------------------------------
	// fields and reset values
	// ------------------------------------------------------------------
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_SWAP_BIT = 1;
	localparam int INT_DONE_BIT = 0;
	localparam int INT_ERR_BIT = 1;
	localparam logic [3:0] ALIGN_RESET = 4'h4;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam time CLK_PERIOD_NS = 40ns;

	// ------------------------------------------------------------------
	// codes
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		S_IDLE = 3'b000, S_SETUP = 3'b001, S_SKIP = 3'b010,
		S_FETCH = 3'b011, S_WAIT = 3'b100, S_EMIT = 3'b101
	} pue_state_type;

	typedef enum logic [4:0] {
		F_STENCIL = 5'h00, F_DEPTH = 5'h01, F_DEPTH_STENCIL = 5'h02,
		F_RED = 5'h03, F_GREEN = 5'h04, F_BLUE = 5'h05, F_RG = 5'h06,
		F_RGB = 5'h07, F_RGBA = 5'h08, F_BGR = 5'h09,
		F_REV_FOUR = 5'h0a, F_RED_I = 5'h0b, F_GREEN_I = 5'h0c,
		F_BLUE_I = 5'h0d, F_RG_I = 5'h0e, F_RGB_I = 5'h0f,
		F_RGBA_I = 5'h10, F_BGR_I = 5'h11, F_REV_FOUR_I = 5'h12
	} pue_format_type;

	typedef enum logic [4:0] {
		T_UBYTE = 5'h00, T_BYTE = 5'h01, T_USHORT = 5'h02,
		T_SHORT = 5'h03, T_UINT = 5'h04, T_INT = 5'h05,
		T_HALF = 5'h06, T_FLOAT = 5'h07, T_332 = 5'h08,
		T_233R = 5'h09, T_565 = 5'h0a, T_565R = 5'h0b,
		T_4444 = 5'h0c, T_4444R = 5'h0d, T_5551 = 5'h0e,
		T_1555R = 5'h0f, T_8888 = 5'h10, T_8888R = 5'h11,
		T_1010102 = 5'h12, T_2101010R = 5'h13, T_24_8 = 5'h14,
		T_F111110R = 5'h15, T_5999R = 5'h16, T_FDS_PAIR = 5'h17
	} pue_type_type;

	typedef enum logic [1:0] {
		TGT_COLOR = 2'h0, TGT_DEPTH = 2'h1, TGT_STENCIL = 2'h2,
		TGT_DEPTH_STENCIL = 2'h3
	} pue_target_type;

	// ------------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------------
	typedef struct packed {
		logic valid;
		logic [31:0] addr;
	} pue_mem_req_type;

	typedef struct packed {
		logic valid;
		logic [2:0] count;
		pue_target_type target;
		logic integerComps;
		logic stencilIndex;
		logic [3:0][31:0] comp;
	} pue_group_type;

endpackage

// ---- test/pue_mem_model.sv ----
// memory partner: answers each element read after lat cycles
// assumes one read outstanding; bench sets element size
`timescale 1ns/1ns
module pue_mem_model import pue_pkg::*; (
	input wire logic mclk,
	input wire pue_mem_req_type memReq,
	input wire logic [2:0] elemSize,
	input wire logic [3:0] lat,
	output logic [31:0] memRdData,
	output logic memRdValid
);
	logic [3:0] cnt = 4'h0;
	logic [31:0] addr = 32'h0;
	function automatic logic [31:0] elem(input logic [31:0] a);
		logic [31:0] v;
		v = a * 32'h9e3779b1;
		return v & ~(32'hffffffff << (8 * elemSize));
	endfunction
	initial begin
		memRdValid = 1'b0;
		memRdData = 32'h0;
	end
	// idle data toggles so a stale word never passes
	always @(posedge mclk) begin
		memRdValid <= 1'b0;
		memRdData <= ~memRdData;
		if (memReq.valid) begin
			addr <= memReq.addr;
			cnt <= lat;
		end else if (cnt != 4'h0) begin
			cnt <= cnt - 4'h1;
			if (cnt == 4'h1) begin
				memRdValid <= 1'b1;
				memRdData <= elem(addr);
			end
		end
	end
endmodule // pue_mem_model

// ---- test/pixel_unpack_engine_tb.sv ----
// bench: registers, unpack transfers, packed decode, rejects
// assumes the memory model answers every read
`timescale 1ns/1ns
module pixel_unpack_engine_tb import pue_pkg::*; ;
	logic mclk = 1'b0, rst = 1'b1, seen;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, memRdData, rd, v;
	logic [3:0] s_axi_wstrb = 4'hf, lat = 4'h1;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, memRdValid, irq;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic [2:0] elemSize = 3'h1;
	pue_mem_req_type memReq;
	pue_group_type grpOut, grps[$];
	logic [31:0] adrs[$], e[4];
	int failures = 0, cmp_count = 0, cyc = 0;
	pue_unpack_engine dut (.mclk, .sys_rst(rst), .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.memReq, .memRdData, .memRdValid, .grpOut, .irq);
	pue_mem_model mem (.mclk, .memReq, .elemSize, .lat, .memRdData,
		.memRdValid);
	always #20 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc++;
		if (grpOut.valid) grps.push_back(grpOut);
		if (memReq.valid) adrs.push_back(memReq.addr);
		if (cyc == 20000) begin
			failures++;
			conclude();
		end
	end
	task automatic conclude();
		$display("mismatches %0d compares %0d", failures, cmp_count);
		if (failures == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge mclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		rs = s_axi_bresp;
		@(posedge mclk);
	endtask
	task automatic rdr(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge mclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		@(posedge mclk);
	endtask
	task automatic setup(input logic [31:0] f, t, al, rl, sr, sp, w, h, sz);
		logic [31:0] c[9];
		c = '{f, t, al, rl, sr, sp, w, h, 32'h100};
		elemSize <= sz[2:0];
		foreach (c[i]) wr(8'(4 * i + 4), c[i]);
	endtask
	task automatic go(input logic [31:0] ctl);
		grps.delete();
		adrs.delete();
		wr(REG_CTRL, ctl);
		for (int i = 0; i < 3000 && !irq; i++) @(posedge mclk);
		seen = irq;
		rdr(REG_INT_STATUS);
	endtask
	task automatic xf(input logic [31:0] f, t, n, sz, w, h, sp, sr, al, rl, sw);
		logic [31:0] pb, k;
		setup(f, t, al, rl, sr, sp, w, h, sz);
		pb = n * (rl > 0 ? rl : w) * sz;
		if (sz < al) pb = (pb + al - 1) / al * al;
		go(sw * 2 + 1);
		chk(rd, 1);
		chk(grps.size(), w * h);
		for (int i = 0; i < n * w * h; i++) begin
			k = 32'h100 + sp * n * sz + (sr + i / (n * w)) * pb + i % (n * w) * sz;
			v = mem.elem(k);
			if (sw) v = {<<8{v}};
			if (sw) v = v >> (32 - 8 * sz);
			chk(adrs[i], k);
			chk(grps[i / n].comp[i % n], v);
		end
		foreach (grps[g]) begin
			chk(grps[g].count, n);
			chk(grps[g].target, f == 0 ? 2 : f == 1);
			chk(grps[g].stencilIndex, f == F_STENCIL);
			chk(grps[g].integerComps, f > 10);
		end
		rdr(REG_GROUP_CNT);
		chk(rd, w * h);
	endtask
	task automatic pk(input logic [31:0] f, t, sz, sw, n);
		setup(f, t, 4, 0, 0, 0, 1, 1, sz);
		go(sw * 2 + 1);
		v = mem.elem(32'h100);
		if (sw) v = {<<8{v}};
		if (sw) v = v >> (32 - 8 * sz);
		case (t)
			T_565: e = '{v[15:11], v[10:5], v[4:0], 0};
			T_565R: e = '{v[4:0], v[10:5], v[15:11], 0};
			T_233R: e = '{v[2:0], v[5:3], v[7:6], 0};
			T_8888R: e = '{v[7:0], v[15:8], v[23:16], v[31:24]};
			T_1010102: e = '{v[31:22], v[21:12], v[11:2], v[1:0]};
			default: e = '{v, mem.elem(32'h104) & 32'hff, 0, 0};
		endcase
		chk(adrs.size(), t == T_FDS_PAIR ? 2 : 1);
		chk(grps[0].count, n);
		chk(grps[0].target, f == F_DEPTH_STENCIL ? 3 : 0);
		chk(grps[0].stencilIndex, f == F_DEPTH_STENCIL);
		for (int i = 0; i < n; i++)
			chk(grps[0].comp[i], e[i]);
	endtask
	task automatic bad(input logic [31:0] f, t, m);
		setup(f, t, 4, 0, 0, 0, 1, 1, 2);
		wr(REG_INT_MASK, m);
		go(1);
		chk(seen, m != 0);
		chk(adrs.size(), 0);
		chk(rd[1], 1);
		rdr(REG_STATUS);
		chk(rd[1], 1);
		repeat (2) @(posedge mclk);
		chk(irq, 0);
	endtask
	initial begin
		repeat (16) @(posedge mclk);
		rst <= 1'b0;
		rdr(REG_ALIGN);
		chk(rd, ALIGN_RESET);
		rdr(8'h38);
		chk(rs, RESP_SLVERR);
		wr(REG_GROUP_CNT, 0);
		chk(rs, RESP_SLVERR);
		wr(REG_INT_MASK, 3);
		chk(rs, RESP_OKAY);
		xf(F_RGB, T_UBYTE, 3, 1, 2, 2, 1, 1, 4, 3, 1);
		lat <= 4'h6;
		xf(F_RG_I, T_USHORT, 2, 2, 3, 2, 1, 1, 8, 0, 1);
		xf(F_REV_FOUR_I, T_UINT, 4, 4, 1, 2, 0, 1, 2, 0, 1);
		xf(F_STENCIL, T_UBYTE, 1, 1, 3, 2, 2, 0, 1, 0, 0);
		xf(F_DEPTH, T_USHORT, 1, 2, 1, 2, 0, 1, 4, 0, 0);
		pk(F_RGB, T_565, 2, 1, 3);
		pk(F_RGB, T_565R, 2, 0, 3);
		pk(F_RGB, T_233R, 1, 0, 3);
		pk(F_REV_FOUR, T_8888R, 4, 1, 4);
		pk(F_RGBA, T_1010102, 4, 0, 4);
		pk(F_DEPTH_STENCIL, T_FDS_PAIR, 4, 0, 2);
		bad(F_RGBA, T_565, 3);
		bad(F_RGB, T_5999R, 0);
		conclude();
	end
endmodule // pixel_unpack_engine_tb
